// *** imc_pkg.sv ***
/*
  constants and types of the two-wire host sequencer: register offsets,
  field positions, reset values, bit counts, state and operation codes.
  assumes an apb slave with 32-bit data and one aligned word per register.
*/
package imc_pkg;
  // ------------------------------------------------------------
  // register offsets (byte addresses)
  // ------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL2 = 8'h00;     // i2c_control_two
  localparam logic [7:0] OFF_BUF = 8'h04;       // serial_data_buffer
  localparam logic [7:0] OFF_RATE = 8'h08;      // rate_reload_value
  localparam logic [7:0] OFF_CFG = 8'h0c;       // mode select
  localparam logic [7:0] OFF_IRQ_STAT = 8'h10;  // sticky event flags
  localparam logic [7:0] OFF_IRQ_MASK = 8'h14;  // event enables

  // ------------------------------------------------------------
  // i2c_control_two, cfg and event flag field positions
  // ------------------------------------------------------------
  localparam int B_GENERAL_CALL_ENABLE = 7;    // general_call_enable
  localparam int B_ACKNOWLEDGE_STATUS_FLAG = 6; // acknowledge_status_flag
  localparam int B_ACKNOWLEDGE_VALUE_BIT = 5;   // acknowledge_value_bit
  localparam int B_ACKNOWLEDGE_SEQUENCE_START = 4;   // acknowledge_sequence_start
  localparam int B_RECEIVE_REQUEST = 3;    // receive_request
  localparam int B_PEN = 2;     // stop_request
  localparam int B_REPEATED_START_REQUEST = 1;    // repeated_start_request
  localparam int B_SEN = 0;     // start_or_stretch_control
  localparam int B_TARGET = 0;  // cfg: 1 = target mode
  localparam int EV_DONE = 0;   // sequence finished
  localparam int EV_NACK = 1;   // target did not acknowledge
  localparam int EV_W = 2;      // number of event flags

  // ------------------------------------------------------------
  // reset values and counts
  // ------------------------------------------------------------
  localparam logic [7:0] CTRL2_RST = 8'h00;
  localparam logic [7:0] BUF_RST = 8'h00;
  localparam logic [7:0] RATE_RST = 8'h4f;
  localparam logic [3:0] TX_BITS = 4'h9;  // eight data bits and the ack slot
  localparam logic [3:0] RX_BITS = 4'h8;
  localparam logic [3:0] ACK_BITS = 4'h1;

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0, ST_A = 4'h1, ST_B = 4'h2, RS_A = 4'h3, RS_B = 4'h4, RS_C = 4'h5,
    SP_A = 4'h6, SP_B = 4'h7, BT_LO = 4'h8, BT_HI = 4'h9
  } imc_state_type;
  typedef enum logic [1:0] {OP_TX = 2'h0, OP_RX = 2'h1, OP_ACK = 2'h2} imc_op_type;
endpackage

// *** imc_brg_if.sv ***
/*
  link between the sequencer and its baud rate generator.
  assumes both ends run on pclk.
*/
`timescale 1ns/10ps
interface imc_brg_if #(parameter int RATE_W = 8);
  logic run;                  // sequence active, counter runs
  logic hold;                 // scl stretched by the target, pause
  logic [RATE_W-1:0] reload;  // rate_reload_value
  logic tick;                 // one half scl period has elapsed
  modport engine (output run, output hold, output reload, input tick);
  modport gen (input run, input hold, input reload, output tick);
endinterface

// *** imc_brg.sv ***
/*
  baud_rate_generator: reload down-counter, two reloads per scl period.
  assumes pclk plays the oscillator; reload values below 3 are not used.
*/
`timescale 1ns/10ps
module imc_brg #(
  parameter int RATE_W = 8
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // sequencer side
  imc_brg_if.gen bus
);
  localparam int CW = RATE_W + 1;

  // ------------------------------------------------------------
  // elaboration check
  // ------------------------------------------------------------
  if (RATE_W < 2 || RATE_W > 16) begin : g_bad_width
    $error("imc_brg: RATE_W out of range");
  end

  logic [CW-1:0] cnt_q; // half-period down count
  logic [CW-1:0] cnt_d;
  logic [CW-1:0] load;  // 2*reload+1 gives 2*(reload+1) cycles per half

  // ------------------------------------------------------------
  // counter
  // ------------------------------------------------------------
  // reload on every tick; stays loaded while stopped so the first
  // half period after a buffer write is a full one
  always_comb begin
    load = {bus.reload, 1'b1};
    if (!bus.run) begin
      cnt_d = load;
    end else if (bus.hold) begin
      cnt_d = cnt_q; // target stretches scl, freeze
    end else if (cnt_q == '0) begin
      cnt_d = load;
    end else begin
      cnt_d = CW'(cnt_q - 1'b1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign bus.tick = bus.run && !bus.hold && (cnt_q == '0);

  // ------------------------------------------------------------
  // checks: spacing of ticks
  // ------------------------------------------------------------
  logic [CW-1:0] gap_q; // advancing cycles since last tick
  logic chg_q;          // reload changed inside the window
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_q <= '0;
      chg_q <= 1'b0;
    end else begin
      gap_q <= (!bus.run || bus.tick) ? '0 : (bus.hold ? gap_q : CW'(gap_q + 1'b1));
      chg_q <= (!bus.run || bus.tick) ? 1'b0 : (chg_q || (bus.reload != $past(bus.reload)));
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  half_period_a: assert property (
    (bus.tick && !chg_q) |-> (gap_q == {bus.reload, 1'b1}))
    else $error("half period is not 2*(reload+1) cycles");
  rate_table_a: assert property (
    (bus.tick && !chg_q && bus.reload == RATE_W'(8'h4f)) |-> (gap_q == CW'(9'h09f)))
    else $error("reload 4f does not give 160 cycles per half period");
endmodule

// *** imc_i2c_ctrl.sv ***
/*
  two-wire bus host sequencer with apb registers: start, repeated start,
  stop, byte transmit, byte receive and acknowledge, plus event interrupt.
  assumes pins are open drain with external pull-ups, inputs synchronous.
*/
// The address map and register access over APB were decided locally.
`timescale 1ns/10ps
module imc_i2c_ctrl (
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // two-wire pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic scl_oe,
  output logic sda_o,
  output logic sda_oe,
  // target mode settings
  output logic stretch_en,
  output logic gcall_en,
  // interrupt
  output logic irq
);
  // ------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------
  imc_pkg::imc_state_type state_q, state_d; // sequencer state
  imc_pkg::imc_op_type op_q, op_d;          // byte-level operation
  logic [3:0] cnt_q, cnt_d;                 // bits left in operation
  logic [7:0] sh_q, sh_d;                   // shift register
  logic scl_oe_q, scl_oe_d;                 // pull scl low
  logic sda_oe_q, sda_oe_d;                 // pull sda low
  logic [7:0] ctrl_q, ctrl_d;               // i2c_control_two
  logic [7:0] buf_q, buf_d;                 // serial_data_buffer
  logic [7:0] rate_q, rate_d;               // rate_reload_value
  logic target_q, target_d;                 // target mode
  logic tx_go_q, tx_go_d;                   // buffer written, send byte
  logic [imc_pkg::EV_W-1:0] stat_q, stat_d; // sticky events
  logic [imc_pkg::EV_W-1:0] mask_q, mask_d; // event enables
  logic [imc_pkg::EV_W-1:0] ev;             // event pulses
  logic irq_q, irq_d;
  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;
  logic [31:0] prdata_q, prdata_d;
  logic stretch_q, gcall_q;
  logic [4:0] fin;                          // request bits to clear
  logic ack_upd, rx_load, tx_take, tick;
  logic idle, acc, wr_en;

  imc_brg_if #(.RATE_W(8)) brg_bus ();

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // level to pull on sda for the coming bit; tx releases the ack slot
  function automatic logic imc_drive(imc_pkg::imc_op_type op, logic [3:0] cnt, logic msb, logic acknowledge_value_bit);
    logic low;
    low = 1'b0;
    if (op == imc_pkg::OP_TX) begin
      low = (cnt > 4'h1) && !msb;
    end else if (op == imc_pkg::OP_ACK) begin
      low = !acknowledge_value_bit;
    end
    return low;
  endfunction

  // keep only the highest-priority request so nothing is queued
  function automatic logic [4:0] imc_pick(logic [4:0] req);
    return req & 5'(~req + 5'h01);
  endfunction

  // ------------------------------------------------------------
  // baud rate generator
  // ------------------------------------------------------------
  assign brg_bus.run = (state_q != imc_pkg::ST_IDLE);
  assign brg_bus.hold = !scl_oe_q && !scl_i; // scl released but held low
  assign brg_bus.reload = rate_q;
  assign tick = brg_bus.tick;

  imc_brg #(.RATE_W(8)) u_brg (
    .pclk(pclk),
    .presetn(presetn),
    .bus(brg_bus)
  );

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  // one state per half scl period; every move except the one out of ST_IDLE waits for a tick
  always_comb begin
    state_d = state_q;
    op_d = op_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    scl_oe_d = scl_oe_q;
    sda_oe_d = sda_oe_q;
    fin = 5'h00;
    ack_upd = 1'b0;
    rx_load = 1'b0;
    tx_take = 1'b0;
    unique case (state_q)
      imc_pkg::ST_IDLE: begin
        if (!target_q) begin
          if (ctrl_q[imc_pkg::B_SEN]) begin
            state_d = imc_pkg::ST_A;
          end else if (ctrl_q[imc_pkg::B_REPEATED_START_REQUEST]) begin
            sda_oe_d = 1'b0;
            state_d = imc_pkg::RS_A;
          end else if (ctrl_q[imc_pkg::B_PEN]) begin
            sda_oe_d = 1'b1;
            state_d = imc_pkg::SP_A;
          end else if (ctrl_q[imc_pkg::B_RECEIVE_REQUEST]) begin
            op_d = imc_pkg::OP_RX;
            cnt_d = imc_pkg::RX_BITS;
            state_d = imc_pkg::BT_LO;
          end else if (ctrl_q[imc_pkg::B_ACKNOWLEDGE_SEQUENCE_START]) begin
            op_d = imc_pkg::OP_ACK;
            cnt_d = imc_pkg::ACK_BITS;
            state_d = imc_pkg::BT_LO;
          end else if (tx_go_q) begin
            op_d = imc_pkg::OP_TX;
            cnt_d = imc_pkg::TX_BITS;
            sh_d = buf_q;
            tx_take = 1'b1;
            state_d = imc_pkg::BT_LO;
          end
          if (state_d == imc_pkg::BT_LO) begin
            sda_oe_d = imc_drive(op_d, cnt_d, sh_d[7], ctrl_q[imc_pkg::B_ACKNOWLEDGE_VALUE_BIT]);
          end
        end
      end
      imc_pkg::ST_A: begin
        if (tick) begin
          sda_oe_d = 1'b1; // sda falls while scl high
          state_d = imc_pkg::ST_B;
        end
      end
      imc_pkg::ST_B: begin
        if (tick) begin
          scl_oe_d = 1'b1;
          fin[imc_pkg::B_SEN] = 1'b1;
          state_d = imc_pkg::ST_IDLE;
        end
      end
      imc_pkg::RS_A: begin
        if (tick) begin
          scl_oe_d = 1'b0;
          state_d = imc_pkg::RS_B;
        end
      end
      imc_pkg::RS_B: begin
        if (tick) begin
          sda_oe_d = 1'b1;
          state_d = imc_pkg::RS_C;
        end
      end
      imc_pkg::RS_C: begin
        if (tick) begin
          scl_oe_d = 1'b1;
          fin[imc_pkg::B_REPEATED_START_REQUEST] = 1'b1;
          state_d = imc_pkg::ST_IDLE;
        end
      end
      imc_pkg::SP_A: begin
        if (tick) begin
          scl_oe_d = 1'b0;
          state_d = imc_pkg::SP_B;
        end
      end
      imc_pkg::SP_B: begin
        if (tick) begin
          sda_oe_d = 1'b0; // sda rises while scl high
          fin[imc_pkg::B_PEN] = 1'b1;
          state_d = imc_pkg::ST_IDLE;
        end
      end
      imc_pkg::BT_LO: begin
        if (tick) begin
          scl_oe_d = 1'b0;
          state_d = imc_pkg::BT_HI;
        end
      end
      imc_pkg::BT_HI: begin
        if (tick) begin
          scl_oe_d = 1'b1;
          sh_d = {sh_q[6:0], sda_i};
          cnt_d = cnt_q - 4'h1;
          if (cnt_q == 4'h1) begin
            sda_oe_d = 1'b0; // host keeps scl low, sda free
            state_d = imc_pkg::ST_IDLE;
            ack_upd = (op_q == imc_pkg::OP_TX);
            rx_load = (op_q == imc_pkg::OP_RX);
            fin[imc_pkg::B_RECEIVE_REQUEST] = (op_q == imc_pkg::OP_RX);
            fin[imc_pkg::B_ACKNOWLEDGE_SEQUENCE_START] = (op_q == imc_pkg::OP_ACK);
          end else begin
            sda_oe_d = imc_drive(op_q, cnt_d, sh_d[7], ctrl_q[imc_pkg::B_ACKNOWLEDGE_VALUE_BIT]);
            state_d = imc_pkg::BT_LO;
          end
        end
      end
      default: begin
        state_d = imc_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= imc_pkg::ST_IDLE;
      op_q <= imc_pkg::OP_TX;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end else begin
      state_q <= state_d;
      op_q <= op_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      scl_oe_q <= scl_oe_d;
      sda_oe_q <= sda_oe_d;
    end
  end

  // ------------------------------------------------------------
  // registers and apb
  // ------------------------------------------------------------
  // one wait state: answer in the second access cycle, writes commit there
  assign idle = (state_q == imc_pkg::ST_IDLE) && (ctrl_q[4:0] == 5'h00) && !tx_go_q;
  assign acc = psel && penable;
  assign wr_en = acc && pready_q && pwrite;

  always_comb begin
    ctrl_d = ctrl_q & ~{3'h0, fin};
    buf_d = buf_q;
    rate_d = rate_q;
    target_d = target_q;
    mask_d = mask_q;
    tx_go_d = tx_go_q && !tx_take;
    ev = '0;
    ev[imc_pkg::EV_DONE] = (state_q != imc_pkg::ST_IDLE) && (state_d == imc_pkg::ST_IDLE);
    ev[imc_pkg::EV_NACK] = ack_upd && sda_i;
    stat_d = stat_q;
    if (ack_upd) begin
      ctrl_d[imc_pkg::B_ACKNOWLEDGE_STATUS_FLAG] = sda_i; // high line = no acknowledge
    end
    if (rx_load) begin
      buf_d = {sh_q[6:0], sda_i};
    end
    if (wr_en) begin
      unique case (paddr)
        imc_pkg::OFF_CTRL2: begin
          ctrl_d[imc_pkg::B_GENERAL_CALL_ENABLE] = pwdata[imc_pkg::B_GENERAL_CALL_ENABLE];
          ctrl_d[imc_pkg::B_ACKNOWLEDGE_VALUE_BIT] = pwdata[imc_pkg::B_ACKNOWLEDGE_VALUE_BIT];
          if (target_q) begin
            ctrl_d[imc_pkg::B_SEN] = pwdata[imc_pkg::B_SEN]; // plain stretch bit
          end else if (idle) begin
            ctrl_d[4:0] = imc_pick(pwdata[4:0]); // busy writes dropped
          end
        end
        imc_pkg::OFF_BUF: begin
          if (idle) begin
            buf_d = pwdata[7:0];
            tx_go_d = !target_q;
          end
        end
        imc_pkg::OFF_RATE: rate_d = pwdata[7:0];
        imc_pkg::OFF_CFG: target_d = pwdata[imc_pkg::B_TARGET];
        imc_pkg::OFF_IRQ_STAT: stat_d = stat_q & ~pwdata[imc_pkg::EV_W-1:0];
        imc_pkg::OFF_IRQ_MASK: mask_d = pwdata[imc_pkg::EV_W-1:0];
        default: begin
        end
      endcase
    end
    stat_d = stat_d | ev; // a new event beats a clear
    irq_d = |(stat_q & mask_q);
    pready_d = acc && !pready_q;
    pslverr_d = 1'b0;
    prdata_d = 32'h0000_0000;
    if (acc && !pready_q) begin
      unique case (paddr)
        imc_pkg::OFF_CTRL2: prdata_d = {24'h000000, ctrl_q};
        imc_pkg::OFF_BUF: prdata_d = {24'h000000, buf_q};
        imc_pkg::OFF_RATE: prdata_d = {24'h000000, rate_q};
        imc_pkg::OFF_CFG: prdata_d = {31'h0, target_q};
        imc_pkg::OFF_IRQ_STAT: prdata_d = {30'h0, stat_q};
        imc_pkg::OFF_IRQ_MASK: prdata_d = {30'h0, mask_q};
        default: pslverr_d = 1'b1; // unmapped
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= imc_pkg::CTRL2_RST;
      buf_q <= imc_pkg::BUF_RST;
      rate_q <= imc_pkg::RATE_RST;
      target_q <= 1'b0;
      tx_go_q <= 1'b0;
      stat_q <= '0;
      mask_q <= '0;
      irq_q <= 1'b0;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      stretch_q <= 1'b0;
      gcall_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      buf_q <= buf_d;
      rate_q <= rate_d;
      target_q <= target_d;
      tx_go_q <= tx_go_d;
      stat_q <= stat_d;
      mask_q <= mask_d;
      irq_q <= irq_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q <= prdata_d;
      stretch_q <= target_q && ctrl_q[imc_pkg::B_SEN];
      gcall_q <= target_q && ctrl_q[imc_pkg::B_GENERAL_CALL_ENABLE];
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign scl_o = 1'b0 & scl_oe_q; // open drain: only ever pulls low
  assign sda_o = 1'b0 & sda_oe_q;
  assign scl_oe = scl_oe_q;
  assign sda_oe = sda_oe_q;
  assign stretch_en = stretch_q;
  assign gcall_en = gcall_q;
  assign irq = irq_q;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence start_tail;
    (sda_oe_q && !scl_oe_q && state_q == imc_pkg::ST_B) ##[1:600]
      (state_q == imc_pkg::ST_IDLE && scl_oe_q && !ctrl_q[imc_pkg::B_SEN]);
  endsequence
  sequence stop_tail;
    (!scl_oe_q && sda_oe_q) ##[1:600] (state_q == imc_pkg::ST_IDLE && !sda_oe_q && !ctrl_q[imc_pkg::B_PEN]);
  endsequence

  ctrl_read_a: assert property (
    (acc && !pready_q && !pwrite && paddr == imc_pkg::OFF_CTRL2) |=> (prdata_q == {24'h000000, $past(ctrl_q)}))
    else $error("control two readback wrong");
  acknowledge_status_flag_ro_a: assert property (
    (wr_en && paddr == imc_pkg::OFF_CTRL2 && state_q == imc_pkg::ST_IDLE) |=> $stable(ctrl_q[imc_pkg::B_ACKNOWLEDGE_STATUS_FLAG]))
    else $error("software changed ack status");
  acknowledge_status_flag_cap_a: assert property (
    (state_q == imc_pkg::BT_HI && tick && op_q == imc_pkg::OP_TX && cnt_q == 4'h1)
      |=> (ctrl_q[imc_pkg::B_ACKNOWLEDGE_STATUS_FLAG] == $past(sda_i)))
    else $error("ack status not captured from sda");
  ack_drive_a: assert property (
    (state_q == imc_pkg::BT_HI && op_q == imc_pkg::OP_ACK) |-> (sda_oe_q == !ctrl_q[imc_pkg::B_ACKNOWLEDGE_VALUE_BIT]))
    else $error("ack bit on sda does not match ack value");
  ack_clear_a: assert property (
    (state_q == imc_pkg::BT_HI && tick && op_q == imc_pkg::OP_ACK)
      |=> (!ctrl_q[imc_pkg::B_ACKNOWLEDGE_SEQUENCE_START] && state_q == imc_pkg::ST_IDLE && scl_oe_q))
    else $error("ack request not cleared at end");
  rx_byte_a: assert property (
    (state_q == imc_pkg::BT_HI && tick && op_q == imc_pkg::OP_RX && cnt_q == 4'h1)
      |=> (buf_q == {$past(sh_q[6:0]), $past(sda_i)} && !ctrl_q[imc_pkg::B_RECEIVE_REQUEST]))
    else $error("received byte not loaded");
  buf_block_a: assert property (
    (wr_en && paddr == imc_pkg::OFF_BUF && state_q != imc_pkg::ST_IDLE && !rx_load) |=> $stable(buf_q))
    else $error("buffer written during a sequence");
  start_seq_a: assert property (
    (state_q == imc_pkg::ST_A && tick) |=> start_tail)
    else $error("start condition malformed");
  stop_seq_a: assert property (
    (state_q == imc_pkg::SP_A && tick) |=> stop_tail)
    else $error("stop condition malformed");
  stretch_cfg_a: assert property (
    (target_q && ctrl_q[imc_pkg::B_SEN]) ##1 (target_q && ctrl_q[imc_pkg::B_SEN]) |-> stretch_en)
    else $error("stretch enable not reflected");
endmodule

// *** imc_target_model.sv ***
/*
  two-wire target model facing the host sequencer: acks or not, sends a byte.
  assumes the bench resolves open-drain lines with pull-ups to 1.
*/
`timescale 1ns/10ps
module imc_target_model (
  // clock and bus lines
  input wire logic pclk,
  input wire logic scl,
  input wire logic sda,
  // behaviour chosen by the bench
  input wire logic ack_en,
  input wire logic rx_mode,
  input wire logic [7:0] tx_byte,
  // what the target saw, and its drive
  output logic [7:0] got_byte,
  output logic ack_seen,
  output logic sda_oe
);
  // ----------------------------------------
  // line history and bit slot
  // ----------------------------------------
  logic scl_q = 1'b1; // previous scl
  logic sda_q = 1'b1; // previous sda
  logic [3:0] cnt = 4'hf; // f until the first low phase after a start
  // slot counter: nine slots a byte, data msb first
  always @(posedge pclk) begin
    scl_q <= scl;
    sda_q <= sda;
    if (scl && scl_q && sda_q && !sda) cnt <= 4'hf;
    else if (scl_q && !scl) cnt <= (cnt == 4'h8 || cnt == 4'hf) ? 4'h0 : cnt + 4'h1;
    if (scl && !scl_q && cnt < 4'h8) got_byte <= {got_byte[6:0], sda};
    if (scl && !scl_q && cnt == 4'h8) ack_seen <= sda;
  end
  // data bits while sending, ack slot while listening; released otherwise
  assign sda_oe = rx_mode ? (cnt < 4'h8 && !tx_byte[3'h7 - cnt[2:0]]) : (cnt == 4'h8 && ack_en);
endmodule

// *** imc_i2c_ctrl_tb.sv ***
/*
  self-checking bench of the host sequencer: apb tasks and call sequences.
  assumes a target model on open-drain lines with pull-ups.
*/
`timescale 1ns/10ps
module imc_i2c_ctrl_tb;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, st;
  logic pready, pslverr, err, scl_o, scl_oe, sda_o, sda_oe, stretch_en, gcall_en, irq;
  logic ack_en = 1'b1, rx_mode = 1'b0, ack_seen, t_oe;
  logic [7:0] got_byte;
  wire logic scl = !scl_oe; // pull-up unless pulled low
  wire logic sda = !(sda_oe || t_oe);
  int n_errors = 0, check_count = 0;
  realtime last_rise = 0, per = 0; // scl period
  always #5 pclk = !pclk;
  always @(posedge scl) begin
    per = $realtime - last_rise;
    last_rise = $realtime;
  end
  imc_i2c_ctrl DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_i(scl),
    .sda_i(sda), .scl_o(scl_o), .scl_oe(scl_oe), .sda_o(sda_o), .sda_oe(sda_oe),
    .stretch_en(stretch_en), .gcall_en(gcall_en), .irq(irq));
  imc_target_model TGT (.pclk(pclk), .scl(scl), .sda(sda), .ack_en(ack_en), .rx_mode(rx_mode),
    .tx_byte(8'h3c), .got_byte(got_byte), .ack_seen(ack_seen), .sda_oe(t_oe));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task final_report();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      n_errors++;
    end
  endtask
  // one apb transfer; request held until pready is sampled high
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int i;
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= wd; penable <= 1'b0;
    @(posedge pclk) penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin n_errors++; final_report(); end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask
  // waits for the done event, then clears it; no new request before that
  task done();
    int i;
    for (i = 0; i < 400; i++) begin
      apb(1'b0, imc_pkg::OFF_IRQ_STAT, 32'h0);
      if (rd[0] === 1'b1) break;
    end
    if (i == 400) begin n_errors++; final_report(); end
    st = rd;
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, imc_pkg::OFF_IRQ_STAT, 32'h3);
    apb(1'b0, imc_pkg::OFF_IRQ_STAT, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, irq}, 32'h0);
    apb(1'b0, imc_pkg::OFF_CTRL2, 32'h0);
    chk(rd & 32'h1f, 32'h0);
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, imc_pkg::OFF_CTRL2, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, imc_pkg::OFF_RATE, 32'h0);
    chk(rd, 32'h4f);
    apb(1'b0, 8'h40, 32'h0);
    chk({31'h0, err}, 32'h1);
    $display("test reset done");
    apb(1'b1, imc_pkg::OFF_RATE, 32'h3);
    apb(1'b1, imc_pkg::OFF_IRQ_MASK, 32'h1);
    apb(1'b1, imc_pkg::OFF_CTRL2, 32'h1);
    done();
    apb(1'b1, imc_pkg::OFF_BUF, 32'ha5);
    apb(1'b1, imc_pkg::OFF_BUF, 32'h5a);
    apb(1'b1, imc_pkg::OFF_CTRL2, 32'h4);
    done();
    chk(st, 32'h1);
    chk({24'h0, got_byte}, 32'ha5);
    chk(int'(per), 32'd160);
    ack_en <= 1'b0;
    apb(1'b1, imc_pkg::OFF_BUF, 32'hc3);
    done();
    chk(st, 32'h3);
    chk({31'h0, ack_seen}, 32'h1);
    $display("test transmit done");
    rx_mode <= 1'b1;
    // first pass answers acknowledge, second not-acknowledge
    for (int k = 0; k < 2; k++) begin
      apb(1'b1, imc_pkg::OFF_CTRL2, 32'h8);
      done();
      apb(1'b0, imc_pkg::OFF_BUF, 32'h0);
      chk(rd, 32'h3c);
      apb(1'b1, imc_pkg::OFF_CTRL2, {26'h0, k[0], 5'h10});
      done();
      chk({31'h0, ack_seen}, {31'h0, k[0]});
    end
    rx_mode <= 1'b0;
    $display("test receive done");
    apb(1'b1, imc_pkg::OFF_RATE, 32'h4f);
    apb(1'b1, imc_pkg::OFF_CTRL2, 32'h2);
    done();
    apb(1'b1, imc_pkg::OFF_CTRL2, 32'h4);
    done();
    chk({30'h0, scl, sda}, 32'h3);
    apb(1'b1, imc_pkg::OFF_CFG, 32'h1);
    apb(1'b1, imc_pkg::OFF_CTRL2, 32'h81);
    // target flags follow the control register one edge later
    @(posedge pclk);
    chk({30'h0, stretch_en, gcall_en}, 32'h3);
    chk({30'h0, scl_o, sda_o}, 32'h0);
    apb(1'b0, imc_pkg::OFF_CTRL2, 32'h0);
    // ack status still holds the not-acknowledge of the last transmit
    chk(rd, 32'hc1);
    $display("test bus conditions done");
    final_report();
  end
endmodule
